/* rtl/csw_pkg.sv */
package csw_pkg;

  // ==========================================================
  // register map
  localparam logic [31:0] CSW_CTRL_ADDR = 32'h0000_ff00;
  localparam logic [31:0] CSW_STAT_ADDR = 32'h0000_ff04;
  localparam logic [3:0]  CSW_CTRL_RESET = 4'h0;
  localparam logic [31:0] CSW_RD_UNMAPPED = 32'h0000_0000;

  // control field positions
  localparam int CSW_VSW_BIT   = 0;
  localparam int CSW_RSVD_BIT  = 1;
  localparam int CSW_OSCEN_BIT = 2;
  localparam int CSW_SEL_BIT   = 3;

  // status field positions
  localparam int CSW_ST_SLOW_ON  = 0;
  localparam int CSW_ST_FAST_ON  = 1;
  localparam int CSW_ST_SETTLED  = 2;
  localparam int CSW_ST_SWITCHING = 3;

  // ==========================================================
  // timing
  localparam int CSW_SYS_CLK_HZ   = 100_000_000;
  localparam int CSW_SETTLE_MS    = 5;
  localparam int CSW_SETTLE_CYCLES =
    (CSW_SETTLE_MS * (CSW_SYS_CLK_HZ / 1000));
  localparam int CSW_SETTLE_W     = 20;
  // one-cycle instruction: 61 us slow, 0.5 us at 4 MHz fast
  localparam int CSW_INSN1_SLOW_US = 61;
  localparam int CSW_INSN1_FAST_NS = 500;
  localparam int CSW_FAST_MHZ      = 4;
  localparam int CSW_CLKS_PER_INSN =
    (CSW_INSN1_FAST_NS * CSW_FAST_MHZ) / 1000;
  localparam logic [1:0] CSW_INSN_LAST =
    2'(CSW_CLKS_PER_INSN - 1);

  // ==========================================================
  // bus
  localparam logic [2:0] CSW_HSIZE_WORD = 3'h2;
  localparam logic       CSW_HRESP_OKAY = 1'b0;

  // ==========================================================
  // types
  typedef struct packed {
    logic        en;
    logic [31:0] addr;
    logic [31:0] data;
  } csw_wr_s;

  typedef enum logic [2:0] {
    CSW_SW_SLOW      = 3'b000,
    CSW_SW_DROP_SLOW = 3'b001,
    CSW_SW_RAISE_FAST = 3'b010,
    CSW_SW_FAST      = 3'b011,
    CSW_SW_DROP_FAST = 3'b100,
    CSW_SW_RAISE_SLOW = 3'b101
  } csw_sw_e;

endpackage : csw_pkg

/* rtl/csw_clk_leg.sv */
`timescale 1ns/1ps

// ==========================================================
// one gated leg of the processor clock multiplexer
module csw_clk_leg #(
  parameter logic RESET_ON = 1'b0
) (
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic src,
  input  wire logic want,
  output logic      on,
  output logic      part
);

  logic next_on;

  // the gate only moves while the source is low, so no
  // shortened high pulse can leak out
  assign next_on = src ? on : want;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      on   <= RESET_ON;
      part <= 1'b0;
    end else begin
      on   <= next_on;
      part <= src & next_on;
    end
  end

endmodule : csw_clk_leg

/* rtl/csw_ahb.sv */
`timescale 1ns/1ps

// ==========================================================
// ahb-lite slave: writes in zero wait, reads in one wait
module csw_ahb (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output csw_pkg::csw_wr_s wr,
  output logic [31:0]      rd_addr,
  input  wire logic [31:0] rd_data
);

  logic        accept;
  logic        dp_valid;
  logic        dp_write;
  logic        dp_word;
  logic [31:0] dp_addr;

  assign accept  = hsel & htrans[1] & hready;
  assign rd_addr = dp_addr;
  // only whole-word writes land; narrower ones are dropped
  // one driver for the whole struct keeps the write strobe whole
  assign wr = '{en:   dp_valid & dp_write & dp_word & hready,
                addr: dp_addr,
                data: hwdata};

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_word  <= 1'b0;
      dp_addr  <= 32'h0000_0000;
    end else if (hready) begin
      dp_valid <= accept;
      dp_write <= hwrite;
      dp_word  <= (hsize == csw_pkg::CSW_HSIZE_WORD);
      dp_addr  <= haddr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= csw_pkg::CSW_HRESP_OKAY;
    end else begin
      hreadyout <= !(accept & !hwrite);
      hrdata    <= hreadyout ? hrdata : rd_data;
      hresp     <= csw_pkg::CSW_HRESP_OKAY;
    end
  end

endmodule : csw_ahb

/* rtl/csw_clock_switch.sv */
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps

// ==========================================================
// Overview of operation
// - fast oscillator feeds processor, timer and frequency output
// - bit 2 starts and stops fast oscillator; readable; zero at reset
// - bit 3 selects fast processor clock when one, slow when zero
// - fast selection refused while voltage bit or oscillator enable is zero
// - bit 0 read/write, resets zero, gates fast selection and drives voltage_switch_out
// - instruction cycle lasts two processor clocks: 61 us or 0.5 us
module csw_clock_switch #(
  parameter int SETTLE_CYCLES = csw_pkg::CSW_SETTLE_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // oscillators
  input  wire logic        slow_osc,
  input  wire logic        fast_osc,
  output logic             fast_osc_run,
  // generated clocks
  output logic             cpu_clk,
  output logic             cpu_cycle_tick,
  output logic             timer_src_clk,
  output logic             freq_output_src_clk,
  output logic             voltage_switch_out
);

  // ==========================================================
  // bus slave
  csw_pkg::csw_wr_s wr;
  logic [31:0]      rd_addr;
  logic [31:0]      rd_data;

  csw_ahb u_ahb (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hwdata    (hwdata),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .wr        (wr),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data)
  );

  // ==========================================================
  // control register
  logic voltage_switch_bit;
  logic fast_osc_enable;
  logic cpu_clock_select;

  logic wr_ctrl;
  logic w_vsw;
  logic w_en;
  logic w_sel;
  logic sel_allowed;
  logic next_vsw;
  logic next_en;
  logic next_sel;

  assign wr_ctrl = wr.en & (wr.addr == csw_pkg::CSW_CTRL_ADDR);
  assign w_vsw   = wr.data[csw_pkg::CSW_VSW_BIT];
  assign w_en    = wr.data[csw_pkg::CSW_OSCEN_BIT];
  assign w_sel   = wr.data[csw_pkg::CSW_SEL_BIT];

  // oscillator must already be running before this write
  // so an enable-and-select write is refused: no settle time yet
  assign sel_allowed = w_vsw & w_en & fast_osc_enable;

  assign next_vsw = wr_ctrl ? w_vsw : voltage_switch_bit;
  assign next_en  = wr_ctrl ? w_en : fast_osc_enable;
  // a held selection also drops if either gate bit goes low,
  // so the core never sits on a stopped fast source
  assign next_sel = wr_ctrl ? (w_sel & sel_allowed)
                  : (cpu_clock_select & voltage_switch_bit
                     & fast_osc_enable);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      voltage_switch_bit <= csw_pkg::CSW_CTRL_RESET[0];
      fast_osc_enable    <= csw_pkg::CSW_CTRL_RESET[2];
      cpu_clock_select   <= csw_pkg::CSW_CTRL_RESET[3];
    end else begin
      voltage_switch_bit <= next_vsw;
      fast_osc_enable    <= next_en;
      cpu_clock_select   <= next_sel;
    end
  end

  // ==========================================================
  // oscillator sampling and fast oscillator enable
  logic slow_q;
  logic fast_q;
  logic fast_src;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      slow_q       <= 1'b0;
      fast_q       <= 1'b0;
      fast_osc_run <= 1'b0;
    end else begin
      slow_q       <= slow_osc;
      fast_q       <= fast_osc;
      fast_osc_run <= fast_osc_enable;
    end
  end

  // a stopped oscillator counts as held low so the gate can close
  assign fast_src = fast_q & fast_osc_run;

  // ==========================================================
  // settle timer, a software aid only; selection is not held off
  // software still owns the wait; the count only reports it
  logic [csw_pkg::CSW_SETTLE_W-1:0] settle_cnt;
  logic [csw_pkg::CSW_SETTLE_W-1:0] next_settle_cnt;
  logic                             settled;
  logic                             next_settled;

  assign next_settled =
    fast_osc_run
    & (settle_cnt >= csw_pkg::CSW_SETTLE_W'(SETTLE_CYCLES - 1));
  assign next_settle_cnt =
    !fast_osc_run ? '0 :
    settled       ? settle_cnt :
                    settle_cnt + 1'b1;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      settle_cnt <= '0;
      settled    <= 1'b0;
    end else begin
      settle_cnt <= next_settle_cnt;
      settled    <= next_settled;
    end
  end

  // ==========================================================
  // glitch-free break-before-make switch
  csw_pkg::csw_sw_e sw_state;
  csw_pkg::csw_sw_e next_sw_state;

  logic want_slow;
  logic want_fast;
  logic slow_on;
  logic fast_on;
  logic slow_part;
  logic fast_part;
  logic switching;

  always_comb begin
    next_sw_state = sw_state;
    case (sw_state)
      csw_pkg::CSW_SW_SLOW: begin
        if (cpu_clock_select) begin
          next_sw_state = csw_pkg::CSW_SW_DROP_SLOW;
        end
      end
      csw_pkg::CSW_SW_DROP_SLOW: begin
        if (!slow_on) begin
          next_sw_state = cpu_clock_select
                        ? csw_pkg::CSW_SW_RAISE_FAST
                        : csw_pkg::CSW_SW_RAISE_SLOW;
        end
      end
      csw_pkg::CSW_SW_RAISE_FAST: begin
        if (!cpu_clock_select) begin
          next_sw_state = csw_pkg::CSW_SW_DROP_FAST;
        end else if (fast_on) begin
          next_sw_state = csw_pkg::CSW_SW_FAST;
        end
      end
      csw_pkg::CSW_SW_FAST: begin
        if (!cpu_clock_select) begin
          next_sw_state = csw_pkg::CSW_SW_DROP_FAST;
        end
      end
      csw_pkg::CSW_SW_DROP_FAST: begin
        if (!fast_on) begin
          next_sw_state = csw_pkg::CSW_SW_RAISE_SLOW;
        end
      end
      csw_pkg::CSW_SW_RAISE_SLOW: begin
        if (slow_on) begin
          next_sw_state = csw_pkg::CSW_SW_SLOW;
        end
      end
      default: begin
        next_sw_state = csw_pkg::CSW_SW_SLOW;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sw_state <= csw_pkg::CSW_SW_SLOW;
    end else begin
      sw_state <= next_sw_state;
    end
  end

  // only one leg is ever asked to be open at a time
  assign want_slow = (sw_state == csw_pkg::CSW_SW_SLOW)
                   | (sw_state == csw_pkg::CSW_SW_RAISE_SLOW);
  assign want_fast = (sw_state == csw_pkg::CSW_SW_FAST)
                   | (sw_state == csw_pkg::CSW_SW_RAISE_FAST);
  assign switching = (sw_state != csw_pkg::CSW_SW_SLOW)
                   & (sw_state != csw_pkg::CSW_SW_FAST);

  csw_clk_leg #(.RESET_ON(1'b1)) u_leg_slow (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .src     (slow_q),
    .want    (want_slow),
    .on      (slow_on),
    .part    (slow_part)
  );

  csw_clk_leg #(.RESET_ON(1'b0)) u_leg_fast (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .src     (fast_src),
    .want    (want_fast),
    .on      (fast_on),
    .part    (fast_part)
  );

  // ==========================================================
  // processor clock and instruction cycle strobe
  logic       cpu_rise;
  logic [1:0] insn_cnt;
  logic [1:0] next_insn_cnt;
  logic       next_tick;

  // tick closes each two-clock instruction cycle
  assign cpu_rise = (slow_part | fast_part) & !cpu_clk;
  assign next_tick = cpu_rise & (insn_cnt == csw_pkg::CSW_INSN_LAST);
  assign next_insn_cnt = !cpu_rise ? insn_cnt :
                         next_tick ? 2'h0 :
                                     insn_cnt + 2'h1;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cpu_clk        <= 1'b0;
      insn_cnt       <= 2'h0;
      cpu_cycle_tick <= 1'b0;
    end else begin
      cpu_clk        <= slow_part | fast_part;
      insn_cnt       <= next_insn_cnt;
      cpu_cycle_tick <= next_tick;
    end
  end

  // ==========================================================
  // fast clock to the peripherals
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      timer_src_clk       <= 1'b0;
      freq_output_src_clk <= 1'b0;
      voltage_switch_out  <= 1'b0;
    end else begin
      timer_src_clk       <= fast_src;
      freq_output_src_clk <= fast_src;
      // no supply effect; exported for visibility only
      voltage_switch_out  <= voltage_switch_bit;
    end
  end

  // ==========================================================
  // read mux
  logic [3:0] ctrl_view;
  logic [3:0] stat_view;

  assign ctrl_view = {cpu_clock_select, fast_osc_enable,
                      1'b0, voltage_switch_bit};
  assign stat_view = {switching, settled, fast_on, slow_on};

  assign rd_data =
    (rd_addr == csw_pkg::CSW_CTRL_ADDR) ? {28'h000_0000, ctrl_view} :
    (rd_addr == csw_pkg::CSW_STAT_ADDR) ? {28'h000_0000, stat_view} :
                                          csw_pkg::CSW_RD_UNMAPPED;

endmodule : csw_clock_switch

/* tb/csw_clock_switch_monitor.sv */
`timescale 1ns/1ps

// ==========================================================
// port checks for the clock source switch
module csw_clock_switch_monitor #(
  parameter int SETTLE_CYCLES = csw_pkg::CSW_SETTLE_CYCLES
) (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        slow_osc,
  input wire logic        fast_osc,
  input wire logic        fast_osc_run,
  input wire logic        cpu_clk,
  input wire logic        cpu_cycle_tick,
  input wire logic        timer_src_clk,
  input wire logic        freq_output_src_clk,
  input wire logic        voltage_switch_out
);
  default clocking mon_cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  wire logic       ctl_take;
  wire logic       wr_take;
  wire logic       rd_take;
  logic            wr_dp;
  logic [6:0]      slow_cnt;

  assign ctl_take = hsel && htrans[1] && hready
    && hsize == csw_pkg::CSW_HSIZE_WORD && haddr == csw_pkg::CSW_CTRL_ADDR;
  assign wr_take = ctl_take && hwrite;
  assign rd_take = ctl_take && !hwrite;

  // ==========================================================
  // helpers
  always_ff @(posedge sys_clk) begin
    wr_dp <= resetn && wr_take;
  end
  // saturating, so a slow leg left open long stays checked
  always_ff @(posedge sys_clk) begin
    if (!resetn || (voltage_switch_out && fast_osc_run))
      slow_cnt <= 7'h00;
    else if (slow_cnt != 7'h7f)
      slow_cnt <= slow_cnt + 7'h01;
  end

  // ==========================================================
  // assertions
  wr_no_wait_a: assert property (wr_take |=> hreadyout)
    else $error("control write stalled");
  resp_okay_a: assert property (!hresp)
    else $error("bus response not okay");
  rd_one_wait_a: assert property (rd_take |=> !hreadyout ##1 hreadyout)
    else $error("control read wait wrong");
  rsvd_zero_a: assert property (
    rd_take |=> ##1 (hrdata[31:4] == 28'h000_0000 && !hrdata[1]))
    else $error("unused control bit read nonzero");
  run_on_a: assert property (
    wr_dp && hwdata[2] |-> ##[1:3] fast_osc_run)
    else $error("fast oscillator not started");
  run_off_a: assert property (
    wr_dp && !hwdata[2] |-> ##[1:3] !fast_osc_run)
    else $error("fast oscillator not stopped");
  run_held_a: assert property (
    $changed(fast_osc_run) && $past(resetn)
      |-> $past(wr_dp) || $past(wr_dp, 2) || $past(wr_dp, 3))
    else $error("oscillator enable moved without a write");
  timer_gated_a: assert property (
    !fast_osc_run [*4] |-> !timer_src_clk && !freq_output_src_clk)
    else $error("fast clock outputs run while stopped");
  slow_only_a: assert property (
    slow_cnt == 7'h7f && $rose(cpu_clk) |-> $past(slow_osc)
      || $past(slow_osc, 2) || $past(slow_osc, 3) || $past(slow_osc, 4))
    else $error("processor clock not from slow source");

  wr_sel_c: cover property (wr_dp && hwdata[3]);
  fast_tick_c: cover property (fast_osc_run && $rose(cpu_cycle_tick));
  slow_long_c: cover property (slow_cnt == 7'h7f && $rose(cpu_clk));
endmodule : csw_clock_switch_monitor

bind csw_clock_switch csw_clock_switch_monitor #(
  .SETTLE_CYCLES(SETTLE_CYCLES)
) i_monitor (
  .sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
  .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .slow_osc(slow_osc), .fast_osc(fast_osc),
  .fast_osc_run(fast_osc_run), .cpu_clk(cpu_clk),
  .cpu_cycle_tick(cpu_cycle_tick), .timer_src_clk(timer_src_clk),
  .freq_output_src_clk(freq_output_src_clk),
  .voltage_switch_out(voltage_switch_out)
);

/* tb/csw_clock_switch_tb.sv */
`timescale 1ns/1ps

// ==========================================================
// directed bench for the clock source switch
module csw_clock_switch_tb;
  localparam logic [31:0] CTRL = csw_pkg::CSW_CTRL_ADDR;
  localparam logic [31:0] STAT = csw_pkg::CSW_STAT_ADDR;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  localparam logic [31:0] ONE  = 32'h0000_0001;

  logic        sys_clk  = 1'b0;
  logic        resetn   = 1'b0;
  logic        hsel     = 1'b0;
  logic [31:0] haddr    = ZERO;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [31:0] hwdata   = ZERO;
  logic        slow_osc = 1'b0;
  logic        fast_osc = 1'b0;
  logic [3:0]  osc_cnt  = 4'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        fast_osc_run;
  logic        cpu_clk;
  logic        cpu_cycle_tick;
  logic        timer_src_clk;
  logic        freq_output_src_clk;
  logic        voltage_switch_out;
  int          miscompares = 0;
  int          cmp_count   = 0;
  int          cr;
  int          tr;
  int          tk;
  int          fr;

  csw_clock_switch #(.SETTLE_CYCLES(20)) i_dut (
    .sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(csw_pkg::CSW_HSIZE_WORD),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .slow_osc(slow_osc),
    .fast_osc(fast_osc), .fast_osc_run(fast_osc_run), .cpu_clk(cpu_clk),
    .cpu_cycle_tick(cpu_cycle_tick), .timer_src_clk(timer_src_clk),
    .freq_output_src_clk(freq_output_src_clk),
    .voltage_switch_out(voltage_switch_out)
  );

  initial forever #5 sys_clk = ~sys_clk;

  // slow source period 16 cycles, fast source 4
  always @(posedge sys_clk) begin
    osc_cnt  <= osc_cnt + 4'h1;
    slow_osc <= osc_cnt[3];
    fast_osc <= osc_cnt[1];
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic bus(input logic [31:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(a, 1'b0, ZERO, r);
    chk("register read", e, r);
  endtask : rd

  // switch time depends on both sources, so status is polled
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    logic [31:0] r;
    for (int i = 0; i < 100; i++) begin
      bus(STAT, 1'b0, ZERO, r);
      if ((r & m) == v)
        break;
    end
    chk("status", v, r & m);
  endtask : poll

  task automatic measure(input int n);
    logic pc;
    logic pt;
    logic pk;
    logic pf;
    cr = 0;
    tr = 0;
    tk = 0;
    fr = 0;
    pc = cpu_clk;
    pt = timer_src_clk;
    pk = cpu_cycle_tick;
    pf = freq_output_src_clk;
    repeat (n) begin
      @(posedge sys_clk);
      cr += int'(cpu_clk && !pc);
      tr += int'(timer_src_clk && !pt);
      tk += int'(cpu_cycle_tick && !pk);
      fr += int'(freq_output_src_clk && !pf);
      pc = cpu_clk;
      pt = timer_src_clk;
      pk = cpu_cycle_tick;
      pf = freq_output_src_clk;
    end
  endtask : measure

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rd(CTRL, ZERO);
    measure(64);
    chk("cpu slow", ONE, 32'(cr >= 3 && cr <= 5));
  endtask : t_reset

  task automatic t_refuse;
    wr(CTRL, 32'h0000_000b);
    rd(CTRL, ONE);
    chk("vsw out", ONE, 32'(voltage_switch_out));
    chk("run", ZERO, 32'(fast_osc_run));
    wr(32'h0000_ff08, 32'h0000_000f);
    rd(32'h0000_ff08, ZERO);
    wr(CTRL, 32'h0000_0004);
    poll(32'h0000_0004, ZERO);
    wr(CTRL, 32'h0000_000c);
    rd(CTRL, 32'h0000_0004);
    chk("run", ONE, 32'(fast_osc_run));
  endtask : t_refuse

  task automatic t_switch;
    wr(CTRL, 32'h0000_0005);
    poll(32'h0000_0004, 32'h0000_0004);
    wr(CTRL, 32'h0000_000d);
    rd(CTRL, 32'h0000_000d);
    poll(32'h0000_000b, 32'h0000_0002);
    measure(64);
    chk("cpu fast", ONE, 32'(cr >= 14));
    chk("timer fast", ONE, 32'(tr >= 14));
    chk("freq fast", ONE, 32'(fr >= 14));
  endtask : t_switch

  task automatic t_return;
    wr(CTRL, 32'h0000_0005);
    poll(32'h0000_000b, ONE);
    wr(CTRL, ONE);
    rd(CTRL, ONE);
    chk("run off", ZERO, 32'(fast_osc_run));
    measure(256);
    chk("timer off", ZERO, 32'(tr));
    chk("freq off", ZERO, 32'(fr));
    chk("cpu slow", ONE, 32'(cr >= 15 && cr <= 17));
    chk("tick pairs", ONE, 32'(2 * tk >= cr - 1 && 2 * tk <= cr + 1));
  endtask : t_return

  task automatic t_drop;
    wr(CTRL, 32'h0000_0005);
    poll(32'h0000_0004, 32'h0000_0004);
    wr(CTRL, 32'h0000_000d);
    // select kept asking while the voltage bit drops
    wr(CTRL, 32'h0000_000c);
    rd(CTRL, 32'h0000_0004);
    poll(32'h0000_000b, ONE);
    wr(CTRL, ZERO);
  endtask : t_drop

  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    test_done;
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    t_reset;
    t_refuse;
    t_switch;
    t_return;
    t_drop;
    test_done;
  end
endmodule : csw_clock_switch_tb
